//--- hdl/scan_cycle_sequencer_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - three init steps once, then endless cycles
// RULE2 - phases run in the fixed documented order
// RULE3 - overseeing lasts 3.5 ms, reloads watchdog
// RULE4 - calc phase measures, pads minimum, reloads watchdog
// RULE5 - io refresh 70 us in, 40 us out
// RULE6 - plus 1.3 ms per master, 0.2 ms slave
// RULE7 - inputs sampled, outputs driven during io refresh
// RULE8 - host link at most 8 ms per unit
// RULE9 - network link 1.5 ms per unit plus 10 ms
// RULE10 - peripheral time 0, 0.8 ms or T x 0.06
// RULE11 - remote master serviced once per cycle only
// RULE12 - watchdog overrun gives code 9f, halts
// RULE13 - instruction may extend watchdog set value
// RULE14 - cycle of 100 ms sets error flag
// RULE15 - cycle of 6500 ms halts regardless
// RULE16 - 10 ms cycle flags high-speed timer inaccuracy
// RULE17 - 20/100/200 ms flag clock-pulse inaccuracy
// RULE18 - phases never overlap; cycle measured io to io
module scan_cycle_sequencer_watchdog #(
   parameter int unsigned MS_CYCLES = scan_pkg::MS_CYC,  // not used; shortening US_CYCLES shortens simulation
   parameter int unsigned US_CYCLES = scan_pkg::US_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire scan_pkg::config_t i_cfg,
   input wire logic [15:0] i_in_pins,
   input wire logic i_host_req,
   input wire logic i_periph_req,
   input wire logic i_net_req,
   input wire logic i_prog_done,
   input wire logic [15:0] i_min_cycle_ms,
   input wire logic i_wdt_ext_stb,
   input wire logic [15:0] i_wdt_ext_ms,
   input wire logic [9:0] i_hst_timer_number,
   output logic [15:0] o_out_pins,
   output logic [15:0] o_in_bits,
   input wire logic [15:0] i_out_bits,
   output logic o_rio_refresh,
   output scan_pkg::phase_t o_phase,
   output logic o_cycle_start,
   output logic [31:0] o_cycle_us,
   output scan_pkg::health_t o_health,
   output logic o_hst_timer_risk,
   output logic [7:0] o_fatal_error_code,
   output logic o_halted
);
   scan_pkg::phase_t phase_r;          // current phase
   logic [1:0] init_r;                 // init step index
   logic [31:0] tick_r;                // cycles within the current microsecond
   logic [31:0] ph_us_r;               // microseconds spent in phase
   logic [31:0] cyc_us_r;              // microseconds since io refresh start
   logic [31:0] last_cyc_us_r;         // last completed cycle length
   logic [31:0] wdt_us_r;              // watchdog run count
   logic [31:0] wdt_set_ms_r;          // watchdog set value
   logic [31:0] ph_budget;             // budget of current phase
   logic us_tick;                      // one microsecond elapsed
   logic ph_end;                       // current phase done
   logic wdt_reload;                   // watchdog restart
   logic wdt_trip;
   logic hard_trip;

   // converts a millisecond figure to microseconds
   function automatic logic [31:0] ms_to_us(input logic [31:0] ms);
      ms_to_us = ms * 32'd1000;
   endfunction

   assign us_tick = (tick_r == US_CYCLES - 1);

   // microsecond prescaler, one per clock rather than a huge counter per phase
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || us_tick) begin
         tick_r <= scan_pkg::CNT_RST;
      end else begin
         tick_r <= tick_r + 32'd1;
      end
   end

   // per-phase time budget
   always_comb begin
      ph_budget = 32'd1;
      case (phase_r)
         scan_pkg::ST_INIT: ph_budget = scan_pkg::INIT_US;
         scan_pkg::ST_IO: begin
            ph_budget = 32'(i_cfg.in_words) * scan_pkg::IN_WORD_US
                      + 32'(i_cfg.out_words) * scan_pkg::OUT_WORD_US      // see RULE5
                      + 32'(i_cfg.rio_masters) * scan_pkg::RIO_MASTER_US
                      + 32'(i_cfg.rio_slaves) * scan_pkg::RIO_SLAVE_US;  // see RULE6
         end
         scan_pkg::ST_HOST: ph_budget = 32'(i_cfg.host_units) * scan_pkg::HOST_UNIT_US; // see RULE8
         scan_pkg::ST_PERIPH: begin
            if (!i_cfg.periph_present) begin
               ph_budget = 32'd0;                                        // see RULE10
            end else if (last_cyc_us_r <= ms_to_us(scan_pkg::PERIPH_T_MS)) begin
               ph_budget = scan_pkg::PERIPH_US;                          // see RULE10
            end else begin
               ph_budget = last_cyc_us_r * scan_pkg::PERIPH_NUM / scan_pkg::PERIPH_DEN; // see RULE10
            end
         end
         scan_pkg::ST_NET: begin
            ph_budget = 32'(i_cfg.net_units) * scan_pkg::NET_UNIT_US
                      + ((i_cfg.net_units != 4'h0) ? scan_pkg::NET_EXTRA_US : 32'd0); // see RULE9
         end
         scan_pkg::ST_OVER: ph_budget = scan_pkg::OVERSEE_US;            // see RULE3
         scan_pkg::ST_PROG: ph_budget = 32'hffff_ffff;
         scan_pkg::ST_CALC: ph_budget = ms_to_us(32'(i_min_cycle_ms));   // see RULE4
         default: ph_budget = 32'd1;
      endcase
   end

   // phase end: link phases may finish early when units go idle, never overrun
   always_comb begin
      ph_end = 1'b0;
      case (phase_r)
         scan_pkg::ST_HOST: ph_end = (ph_us_r >= ph_budget) || !i_host_req;     // see RULE8
         scan_pkg::ST_PERIPH: ph_end = (ph_us_r >= ph_budget) || !i_periph_req;
         scan_pkg::ST_NET: ph_end = (ph_us_r >= ph_budget) || !i_net_req;       // see RULE9
         scan_pkg::ST_PROG: ph_end = i_prog_done;
         scan_pkg::ST_CALC: ph_end = (cyc_us_r >= ph_budget);                   // see RULE4
         scan_pkg::ST_HALT: ph_end = 1'b0;
         default: ph_end = (ph_us_r >= ph_budget);
      endcase
   end

   // watchdog restart at overseeing entry and calc exit
   assign wdt_reload = (phase_r == scan_pkg::ST_OVER && ph_us_r == 32'd0)     // see RULE3
                    || (phase_r == scan_pkg::ST_CALC && ph_end);                // see RULE4
   assign wdt_trip = (wdt_us_r >= ms_to_us(wdt_set_ms_r));                      // see RULE12
   assign hard_trip = (cyc_us_r >= ms_to_us(scan_pkg::HARD_LIMIT_MS));          // see RULE15

   // phase sequencer, strictly one phase at a time
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         phase_r <= scan_pkg::ST_INIT;
         init_r <= 2'd0;
      end else if (phase_r != scan_pkg::ST_INIT && phase_r != scan_pkg::ST_HALT
                   && (wdt_trip || hard_trip)) begin
         phase_r <= scan_pkg::ST_HALT;                                 // see RULE12 see RULE15
      end else if (ph_end) begin
         case (phase_r)
            scan_pkg::ST_INIT: begin
               init_r <= init_r + 2'd1;
               if (init_r == 2'd2) begin
                  phase_r <= scan_pkg::ST_IO;                          // see RULE1
               end
            end
            scan_pkg::ST_IO: phase_r <= scan_pkg::ST_HOST;             // see RULE2 see RULE18
            scan_pkg::ST_HOST: phase_r <= scan_pkg::ST_PERIPH;
            scan_pkg::ST_PERIPH: phase_r <= scan_pkg::ST_NET;
            scan_pkg::ST_NET: phase_r <= scan_pkg::ST_OVER;
            scan_pkg::ST_OVER: phase_r <= scan_pkg::ST_PROG;
            scan_pkg::ST_PROG: phase_r <= scan_pkg::ST_CALC;
            scan_pkg::ST_CALC: phase_r <= scan_pkg::ST_IO;             // see RULE1
            default: phase_r <= scan_pkg::ST_HALT;
         endcase
      end
   end

   // time spent in phase, cleared at each phase end but not on a trip into halt
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || ph_end) begin
         ph_us_r <= scan_pkg::CNT_RST;
      end else if (us_tick && ph_us_r != 32'hffff_ffff) begin
         ph_us_r <= ph_us_r + 32'd1;
      end
   end

   // cycle timer, from io refresh start to next io refresh start
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cyc_us_r <= scan_pkg::CNT_RST;
         last_cyc_us_r <= scan_pkg::CNT_RST;
      end else if (phase_r == scan_pkg::ST_CALC && ph_end) begin
         cyc_us_r <= scan_pkg::CNT_RST;                                // see RULE18
         last_cyc_us_r <= cyc_us_r;                                    // see RULE4
      end else if (phase_r != scan_pkg::ST_INIT && phase_r != scan_pkg::ST_HALT && us_tick) begin
         cyc_us_r <= cyc_us_r + 32'd1;
      end
   end

   // watchdog counter
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || wdt_reload) begin
         wdt_us_r <= scan_pkg::CNT_RST;
      end else if (us_tick && phase_r != scan_pkg::ST_INIT && phase_r != scan_pkg::ST_HALT) begin
         wdt_us_r <= wdt_us_r + 32'd1;
      end
   end

   // set value: default, or default plus the last extend figure, never below default
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wdt_set_ms_r <= scan_pkg::DEF_WDT_MS;
      end else if (i_wdt_ext_stb && phase_r == scan_pkg::ST_PROG) begin
         wdt_set_ms_r <= scan_pkg::DEF_WDT_MS + 32'(i_wdt_ext_ms);    // see RULE13
      end
   end

   // fatal code latch; stays until reset
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_fatal_error_code <= 8'h00;
      end else if (phase_r != scan_pkg::ST_INIT && phase_r != scan_pkg::ST_HALT
                   && (wdt_trip || hard_trip)) begin
         o_fatal_error_code <= scan_pkg::FATAL_WDT;                    // see RULE12 see RULE15
      end
   end

   // pin refresh only in io phase, held otherwise
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_in_bits <= scan_pkg::WORD_RST;
         o_out_pins <= scan_pkg::WORD_RST;
      end else if (phase_r == scan_pkg::ST_IO && ph_us_r == 32'd0) begin
         o_in_bits <= i_in_pins;                                       // see RULE7
         o_out_pins <= i_out_bits;                                     // see RULE7
      end
   end

   // one remote master exchange per cycle, the clock after io entry
   // keyed to the start pulse so a slow tick cannot repeat it
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_rio_refresh <= 1'b0;
      end else begin
         o_rio_refresh <= o_cycle_start && (i_cfg.rio_masters != 4'h0); // see RULE11
      end
   end

   // cycle start pulse, one clock at io entry
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_cycle_start <= 1'b0;
      end else begin
         o_cycle_start <= ph_end && (phase_r == scan_pkg::ST_CALC ||
                          (phase_r == scan_pkg::ST_INIT && init_r == 2'd2));
      end
   end

   // health flags from the last completed cycle
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_health <= '0;
      end else if (phase_r == scan_pkg::ST_CALC && ph_end) begin
         o_health.cyc_err <= cyc_us_r >= ms_to_us(scan_pkg::ERR_FLAG_MS);       // see RULE14
         o_health.hst_inacc <= cyc_us_r >= ms_to_us(scan_pkg::HST_WARN_MS);     // see RULE16
         o_health.cp002_inacc <= cyc_us_r >= ms_to_us(scan_pkg::CP002_WARN_MS); // see RULE17
         o_health.cp01_inacc <= cyc_us_r >= ms_to_us(scan_pkg::ERR_FLAG_MS);    // see RULE17
         o_health.cp02_inacc <= cyc_us_r >= ms_to_us(scan_pkg::CP02_WARN_MS);   // see RULE17
      end
   end

   // timer number range check for long cycles
   assign o_hst_timer_risk = o_health.hst_inacc && (i_hst_timer_number >= scan_pkg::HST_TN_LO)
                           && (i_hst_timer_number <= scan_pkg::HST_TN_HI);      // see RULE16

   assign o_phase = phase_r;
   assign o_cycle_us = last_cyc_us_r;
   assign o_halted = (phase_r == scan_pkg::ST_HALT);
endmodule
`default_nettype wire

//--- include/scan_pkg.sv
package scan_pkg;
   // clock rate and time units
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned NS_PER_CLK = 8;
   localparam int unsigned CYC_PER_US = 1000 / NS_PER_CLK;
   // phase time figures, microseconds, PERIPH_T_MS in milliseconds
   localparam int unsigned OVERSEE_US = 3500;
   localparam int unsigned IN_WORD_US = 70;
   localparam int unsigned OUT_WORD_US = 40;
   localparam int unsigned RIO_MASTER_US = 1300;
   localparam int unsigned RIO_SLAVE_US = 200;
   localparam int unsigned HOST_UNIT_US = 8000;
   localparam int unsigned NET_UNIT_US = 1500;
   localparam int unsigned NET_EXTRA_US = 10000;
   localparam int unsigned PERIPH_US = 800;
   localparam int unsigned PERIPH_T_MS = 13;
   // peripheral share of a long cycle, 0.06 as 6/100
   localparam int unsigned PERIPH_NUM = 6;
   localparam int unsigned PERIPH_DEN = 100;
   // cycle-time thresholds, milliseconds; INIT_US in microseconds
   localparam int unsigned HST_WARN_MS = 10;
   localparam int unsigned CP002_WARN_MS = 20;
   localparam int unsigned ERR_FLAG_MS = 100;
   localparam int unsigned CP02_WARN_MS = 200;
   localparam int unsigned HARD_LIMIT_MS = 6500;
   localparam int unsigned INIT_US = 100;
   localparam int unsigned DEF_WDT_MS = 130;
   // counts of cycles
   localparam int unsigned US_CYC = CYC_PER_US;
   localparam int unsigned MS_CYC = 1000 * CYC_PER_US;
   // fatal code and flag bit address
   localparam logic [7:0] FATAL_WDT = 8'h9f;
   localparam logic [15:0] CYC_ERR_BIT = 16'h62dd;
   // timer numbers affected by long cycles
   localparam logic [9:0] HST_TN_LO = 10'h010;
   localparam logic [9:0] HST_TN_HI = 10'h1ff;
   // reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   typedef enum logic [8:0] {
      ST_INIT   = 9'h001,
      ST_IO     = 9'h002,
      ST_HOST   = 9'h004,
      ST_PERIPH = 9'h008,
      ST_NET    = 9'h010,
      ST_OVER   = 9'h020,
      ST_PROG   = 9'h040,
      ST_CALC   = 9'h080,
      ST_HALT   = 9'h100
   } phase_t;

   // rack population, set by straps
   typedef struct packed {
      logic [7:0] in_words;
      logic [7:0] out_words;
      logic [3:0] rio_masters;
      logic [5:0] rio_slaves;
      logic [3:0] host_units;
      logic [3:0] net_units;
      logic periph_present;
   } config_t;

   // cycle health summary
   typedef struct packed {
      logic cyc_err;
      logic hst_inacc;
      logic cp002_inacc;
      logic cp01_inacc;
      logic cp02_inacc;
   } health_t;
endpackage

//--- tb/scan_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks on sequencing, refresh and cycle health
module scan_monitor #(
   parameter int unsigned US_CYCLES = 1
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire scan_pkg::config_t i_cfg,
   input wire logic [15:0] i_in_pins,
   input wire logic [15:0] i_out_bits,
   input wire logic [9:0] i_hst_timer_number,
   input wire logic [15:0] o_out_pins,
   input wire logic [15:0] o_in_bits,
   input wire logic o_rio_refresh,
   input wire scan_pkg::phase_t o_phase,
   input wire logic o_cycle_start,
   input wire logic [31:0] o_cycle_us,
   input wire scan_pkg::health_t o_health,
   input wire logic o_hst_timer_risk,
   input wire logic [7:0] o_fatal_error_code,
   input wire logic o_halted
);
   logic [31:0] over_cnt_r; // clocks spent overseeing this cycle
   // cleared at each io refresh so a stuck phase shows as an overlong count
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || o_phase == scan_pkg::ST_IO) begin
         over_cnt_r <= 32'h0000_0000;
      end else if (o_phase == scan_pkg::ST_OVER) begin
         over_cnt_r <= over_cnt_r + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // one-hot phases advance by one place, calculation wraps to io
   phase_order_a: assert property ($changed(o_phase) |-> o_phase == scan_pkg::ST_HALT
      || o_phase == ($past(o_phase) == scan_pkg::ST_CALC ? scan_pkg::ST_IO : $past(o_phase) << 1))
      else $error("phase order broken");
   cycle_mark_a: assert property (
      o_cycle_start == (o_phase == scan_pkg::ST_IO && $past(o_phase) != scan_pkg::ST_IO))
      else $error("cycle start not at io entry");
   io_copy_a: assert property (o_cycle_start |=>
      o_in_bits == $past(i_in_pins) && o_out_pins == $past(i_out_bits))
      else $error("io refresh copy wrong");
   rio_once_a: assert property (
      o_rio_refresh == ($past(o_cycle_start) && i_cfg.rio_masters != 4'h0))
      else $error("remote master service wrong");
   oversee_len_a: assert property (
      $past(o_phase) == scan_pkg::ST_OVER && o_phase != scan_pkg::ST_OVER
      |-> over_cnt_r >= scan_pkg::OVERSEE_US * US_CYCLES
      && over_cnt_r <= (scan_pkg::OVERSEE_US + 2) * US_CYCLES)
      else $error("overseeing length wrong");
   halt_code_a: assert property (o_halted |-> o_phase == scan_pkg::ST_HALT
      && o_fatal_error_code == scan_pkg::FATAL_WDT)
      else $error("halt without fatal code");
   err_flag_a: assert property (
      o_health.cyc_err == (o_cycle_us >= scan_pkg::ERR_FLAG_MS * 1000))
      else $error("cycle error flag wrong");
   hst_risk_a: assert property (o_hst_timer_risk == (o_health.hst_inacc
      && i_hst_timer_number >= scan_pkg::HST_TN_LO && i_hst_timer_number <= scan_pkg::HST_TN_HI))
      else $error("timer risk flag wrong");
   cover property (o_cycle_start);
   cover property (o_rio_refresh);
   cover property (o_hst_timer_risk);
endmodule
`default_nettype wire

//--- tb/rack_units_model.sv
`timescale 1ns/100ps
`default_nettype none
// far-side units: link and peripheral units with work, program runner
module rack_units_model (
   input wire logic i_core_clk,
   input wire scan_pkg::phase_t i_phase,
   input wire logic [2:0] i_busy, // host, peripheral, network still have work
   output logic o_host_req,
   output logic o_periph_req,
   output logic o_net_req,
   output logic o_prog_done
);
   // a busy unit never lets go, so only the budget can end its phase
   always @(negedge i_core_clk) begin
      o_host_req <= i_busy[0] && i_phase == scan_pkg::ST_HOST;
      o_periph_req <= i_busy[1] && i_phase == scan_pkg::ST_PERIPH;
      o_net_req <= i_busy[2] && i_phase == scan_pkg::ST_NET;
      o_prog_done <= i_phase == scan_pkg::ST_PROG; // short program
   end
endmodule
`default_nettype wire

//--- tb/scan_cycle_sequencer_watchdog_bench.sv
`timescale 1ns/100ps
`default_nettype none
// case table drives, a second process checks cycle lengths
module scan_cycle_sequencer_watchdog_bench;
   localparam int unsigned US = 1; // one clock per microsecond keeps runs short
   localparam int unsigned SLACK = 30; // phase hand-over clocks, us
   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   scan_pkg::config_t i_cfg = '0;
   logic [15:0] i_in_pins = 16'h0000, i_out_bits = 16'h0000;
   logic [15:0] i_min_cycle_ms = 16'h0000, i_wdt_ext_ms = 16'h0000;
   logic [9:0] i_hst_timer_number = 10'h000;
   logic i_wdt_ext_stb = 1'b0;
   logic [2:0] busy = 3'h0; // far-side units holding work
   logic i_host_req, i_periph_req, i_net_req, i_prog_done;
   logic [15:0] o_out_pins, o_in_bits;
   logic o_rio_refresh, o_cycle_start, o_hst_timer_risk, o_halted;
   scan_pkg::phase_t o_phase;
   logic [31:0] o_cycle_us;
   scan_pkg::health_t o_health;
   logic [7:0] o_fatal_error_code;
   logic [31:0] seed = 32'h0000_029a; // xorshift state
   int unsigned exp_q[$]; // expected cycle lengths, us
   int errors = 0;
   int samples_checked = 0;
   scan_cycle_sequencer_watchdog #(.US_CYCLES(US)) dut (
      .i_core_clk, .i_sys_rst, .i_cfg, .i_in_pins, .i_host_req, .i_periph_req, .i_net_req,
      .i_prog_done, .i_min_cycle_ms, .i_wdt_ext_stb, .i_wdt_ext_ms, .i_hst_timer_number,
      .o_out_pins, .o_in_bits, .i_out_bits, .o_rio_refresh, .o_phase, .o_cycle_start,
      .o_cycle_us, .o_health, .o_hst_timer_risk, .o_fatal_error_code, .o_halted);
   rack_units_model units (.i_core_clk, .i_phase(o_phase), .i_busy(busy),
      .o_host_req(i_host_req), .o_periph_req(i_periph_req), .o_net_req(i_net_req),
      .o_prog_done(i_prog_done));
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // fresh pins, output bits, timer number and extension every clock
   always @(negedge i_core_clk) begin
      seed = xs(seed);
      i_in_pins <= seed[15:0];
      i_out_bits <= seed[31:16];
      i_hst_timer_number <= seed[9:0];
      i_wdt_ext_stb <= seed[12] & seed[7];
      i_wdt_ext_ms <= {8'h00, seed[27:20]};
   end
   task automatic check(input string what, input logic [31:0] seen, input int unsigned lo);
      samples_checked++;
      if ($isunknown(seen) || seen < lo || seen > lo + SLACK) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, lo, seen);
      end
   endtask
   // oldest note meets the length reported at each cycle start
   always @(negedge i_core_clk) begin
      if (o_cycle_start === 1'b1 && exp_q.size() != 0) begin
         check("o_cycle_us", o_cycle_us, exp_q[0]);
         void'(exp_q.pop_front());
      end
   end
   task automatic wait_start();
      do @(negedge i_core_clk); while (o_cycle_start !== 1'b1);
   endtask
   // settings change in the program phase, so the next cycle is clean
   task automatic run_case(input scan_pkg::config_t c, input logic [2:0] b,
         input logic [15:0] m, input int unsigned lo);
      while (o_phase !== scan_pkg::ST_PROG) @(negedge i_core_clk);
      i_cfg = c;
      busy = b;
      i_min_cycle_ms = m;
      wait_start();
      @(negedge i_core_clk);
      exp_q.push_back(lo);
      wait_start();
   endtask
   task automatic complete_run();
      if (errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      int n;
      repeat (8) @(negedge i_core_clk);
      i_sys_rst = 1'b0;
      n = 0;
      do begin
         @(negedge i_core_clk);
         n++;
      end while (o_cycle_start !== 1'b1 && n < 5000);
      check("init_clocks", 32'(n), 3 * scan_pkg::INIT_US * US);
      // words only; then remote units with an idle host unit; peripheral busy
      run_case({8'h02, 8'h03, 4'h0, 6'h00, 4'h0, 4'h0, 1'b0}, 3'h0, 16'h0000, 3760);
      run_case({8'h01, 8'h01, 4'h1, 6'h04, 4'h1, 4'h0, 1'b0}, 3'h0, 16'h0000, 5710);
      run_case({8'h00, 8'h00, 4'h0, 6'h00, 4'h0, 4'h0, 1'b1}, 3'h2, 16'h0000, 4300);
      // padded minimum, then host and network held busy to their budgets
      run_case({8'h00, 8'h00, 4'h0, 6'h00, 4'h0, 4'h0, 1'b0}, 3'h0, 16'h0006, 6000);
      run_case({8'h00, 8'h00, 4'h0, 6'h00, 4'h1, 4'h1, 1'b0}, 3'h5, 16'h0000, 23000);
      // a 23 ms cycle: timer and 0.02 s pulse flags only
      samples_checked++;
      if (o_health !== 5'h0c) begin
         errors++;
         $display("wrong value o_health expected %0h seen %0h", 5'h0c, o_health);
      end
      repeat (4) @(negedge i_core_clk);
      complete_run();
   end
   // hang guard, well past the expected run length
   initial begin
      #700_000;
      errors++;
      complete_run();
   end
endmodule
bind scan_cycle_sequencer_watchdog scan_monitor #(.US_CYCLES(US_CYCLES)) mon (
   .i_core_clk, .i_sys_rst, .i_cfg, .i_in_pins, .i_out_bits, .i_hst_timer_number, .o_out_pins,
   .o_in_bits, .o_rio_refresh, .o_phase, .o_cycle_start, .o_cycle_us, .o_health,
   .o_hst_timer_risk, .o_fatal_error_code, .o_halted);
`default_nettype wire
